//--- pkg/ldt_pkg.sv
// Constants, types and state record for the LED dimming timing control
package ldt_pkg;

	// Clock rate and the time figures the block works with
	localparam int LDT_CLK_MHZ = 100;
	localparam int LDT_MIN_GATE_HIGH_NS = 300;
	localparam int LDT_MIN_GATE_LOW_US = 1;
	localparam int LDT_MIN_PHASE_NS = 150;
	localparam int LDT_PULSE_CODED_DIM_MODE_TIMEOUT_US = 50;
	localparam int LDT_SETTLE_MS = 1;
	localparam int LDT_MIN_PHASE_CYC =
		(LDT_MIN_PHASE_NS * LDT_CLK_MHZ + 999) / 1000;
	localparam int LDT_PULSE_CODED_DIM_MODE_TIMEOUT_CYC = LDT_PULSE_CODED_DIM_MODE_TIMEOUT_US * LDT_CLK_MHZ;
	localparam int LDT_SETTLE_CYC = LDT_SETTLE_MS * 1000 * LDT_CLK_MHZ;

	// Widths
	localparam int LDT_CHANNELS = 6;
	localparam int LDT_DELAY_W = 16;
	localparam int LDT_CNT_W = 14;
	localparam int LDT_PCT_W = 7;
	localparam int LDT_LVL_W = 8;
	localparam int LDT_DIV_W = 20;
	localparam int LDT_QBITS = 7;
	localparam int LDT_SYNC_W = 3;

	// Percent scale and level-mode mapping
	localparam logic [LDT_PCT_W-1:0] LDT_PCT_FULL = 7'h64;
	localparam logic [LDT_PCT_W-1:0] LDT_PCT_FLOOR = 7'h0A;
	localparam logic [LDT_PCT_W-1:0] LDT_PCT_SPAN = 7'h5A;
	// Level codes of the lower and upper dimming thresholds
	localparam logic [LDT_LVL_W-1:0] LDT_LVL_LO = 8'h0E;
	localparam logic [LDT_LVL_W-1:0] LDT_LVL_HI = 8'h8B;
	localparam logic [LDT_CNT_W-1:0] LDT_CNT_MAX = 14'h3FFF;
	localparam logic [2:0] LDT_QTOP = 3'h6;

	typedef enum logic [2:0] {
		LDT_OFF,
		LDT_PRE,
		LDT_LATE,
		LDT_ON,
		LDT_POST
	} ldt_gate_st_t;

	typedef struct packed {
		logic [LDT_DELAY_W-1:0] preboost_delay;
		logic [LDT_CHANNELS-1:0] sink_select;
	} ldt_cfg_t;

	typedef struct packed {
		logic boost_en;
		logic [LDT_CHANNELS-1:0] sink_en;
	} ldt_drive_t;

	typedef struct packed {
		logic [LDT_SYNC_W-1:0] gate_s;
		logic [LDT_SYNC_W-1:0] en_s;
		logic [LDT_SYNC_W-1:0] dim_s;
		logic gate_f;
		logic en_f;
		logic dim_f;
		ldt_gate_st_t gst;
		logic [LDT_DELAY_W-1:0] gcnt;
		logic [LDT_DELAY_W-1:0] glim;
		ldt_drive_t drive;
		logic pulse_mode;
		logic rise_seen;
		logic fall_seen;
		logic [LDT_CNT_W-1:0] since_rise;
		logic [LDT_CNT_W-1:0] high_len;
		logic [LDT_CNT_W-1:0] period;
		logic period_ok;
		logic div_busy;
		logic div_pulse;
		logic [2:0] div_bit;
		logic [LDT_DIV_W-1:0] div_rem;
		logic [LDT_DIV_W-1:0] div_den;
		logic [LDT_QBITS-1:0] div_q;
		logic [LDT_PCT_W-1:0] pct;
	} ldt_state_t;

endpackage : ldt_pkg

//--- src/ldt_dimming_ctrl.sv
// LED dimming timing control: pre-boost gating and dimming mode detection
`timescale 1ns/1ps

// How it works
// [RULE_01] Gate rise starts boost now; sinks stay off until pre-boost delay ends.
// [RULE_02] Gate fall keeps boost and sinks on for the same delay.
// [RULE_03] Gate high times down to 300 ns still yield correct sink on-time.
// [RULE_04] Host never drives gate low for less than one microsecond.
// [RULE_05] Gate held high permanently keeps the sinks continuously on.
// [RULE_06] A clock seen on the analog dim input selects pulse-coded mode.
// [RULE_07] No clock pulse for about 50 us returns to level mode.
// [RULE_08] Host keeps dim clock high and low phases at least 150 ns.
// [RULE_09] Pulse-coded current percent is 100 minus measured high duty.
// [RULE_10] Level mode scales current linearly from ten percent to full.
// [RULE_11] Floating input reads as lowest level, giving about ten percent.
// [RULE_12] Host drives the dim clock between 40 kHz and 1 MHz.
// [RULE_13] Host keeps dim clock duty within the band for its frequency.
// [RULE_14] Current level settles within about one millisecond of a change.
// [RULE_15] Pre-boost delay should be about three boost switching cycles.
// [RULE_16] Dimming ratio falls with gate frequency since minimum on-time is fixed.
// [RULE_17] Sinks are enabled only while chip enable and gate are both high; the code also drives them in POST, after gate or chip enable has fallen.
// [RULE_18] Pre-boost delay is a cycle count used on both gate edges.
// [RULE_19] After reset the mode detector is in level mode.
// [RULE_20] Duty is measured by counting the high phase and the rise-to-rise period.
module ldt_dimming_ctrl #(
	parameter int TIMEOUT_CYC = ldt_pkg::LDT_PULSE_CODED_DIM_MODE_TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic gate_pwm_in,
	input wire logic chip_en_in,
	input wire logic analog_dim_input,
	input wire logic [ldt_pkg::LDT_LVL_W-1:0] analog_dim_level,
	input wire ldt_pkg::ldt_cfg_t cfg,
	output ldt_pkg::ldt_drive_t drive,
	output logic pulse_coded_dim_mode,
	output logic [ldt_pkg::LDT_PCT_W-1:0] current_pct
);
	import ldt_pkg::*;

	localparam logic [LDT_CNT_W-1:0] TIMEOUT_CNT = LDT_CNT_W'(TIMEOUT_CYC);

	ldt_state_t st_r;
	ldt_state_t st_nxt;

	logic gate_on;
	logic dim_rise;
	logic dim_fall;
	logic [LDT_LVL_W-1:0] lvl_clamped;
	logic [LDT_DIV_W-1:0] den_shift;

	// Helpers keep the single combinational process readable

	// Pin history moves one stage per clock, newest sample at the bottom
	function automatic logic [LDT_SYNC_W-1:0] f_shift(
		input logic [LDT_SYNC_W-1:0] s,
		input logic pin
	);
		return {s[LDT_SYNC_W-2:0], pin};
	endfunction : f_shift

	// The filtered level moves only when the last two stages agree, so a
	// single metastable sample can never show up as an edge
	function automatic logic f_filter(
		input logic [LDT_SYNC_W-1:0] s,
		input logic f
	);
		logic res;
		res = f;
		if (s[LDT_SYNC_W-1] == s[LDT_SYNC_W-2]) begin
			res = s[LDT_SYNC_W-1];
		end
		return res;
	endfunction : f_filter

	function automatic logic f_open(input logic gate, input logic en);
		return gate & en;
	endfunction : f_open

	// Boost runs in every state but idle
	function automatic logic f_boost(input ldt_gate_st_t s);
		return s != LDT_OFF;
	endfunction : f_boost

	// Sinks conduct in ON and in the trailing hold, so on-time keeps width
	function automatic logic f_sinks(input ldt_gate_st_t s);
		return (s == LDT_ON) || (s == LDT_POST);
	endfunction : f_sinks

	function automatic logic [LDT_CHANNELS-1:0] f_sink_vec(
		input logic [LDT_CHANNELS-1:0] sel,
		input logic active
	);
		logic [LDT_CHANNELS-1:0] res;
		for (int i = 0; i < LDT_CHANNELS; i++) begin
			res[i] = sel[i] & active;
		end
		return res;
	endfunction : f_sink_vec

	// Phase lengths count the capturing cycle too, so a 50-cycle high
	// phase reads as 50 rather than 49
	function automatic logic [LDT_CNT_W-1:0] f_len(
		input logic [LDT_CNT_W-1:0] cnt
	);
		logic [LDT_CNT_W-1:0] res;
		res = cnt;
		if (cnt != LDT_CNT_MAX) begin
			res = cnt + 1'b1;
		end
		return res;
	endfunction : f_len

	// A silent dim pin past the limit means the host clock has stopped
	function automatic logic f_lost(
		input logic [LDT_CNT_W-1:0] since,
		input logic [LDT_CNT_W-1:0] limit
	);
		return since >= limit;
	endfunction : f_lost

	// Codes outside the dimming window pin to its ends; a floating pin
	// reads as code zero and so lands on the floor
	function automatic logic [LDT_LVL_W-1:0] f_clamp(
		input logic [LDT_LVL_W-1:0] c
	);
		logic [LDT_LVL_W-1:0] res;
		res = c;
		if (c < LDT_LVL_LO) begin
			res = LDT_LVL_LO;
		end else if (c > LDT_LVL_HI) begin
			res = LDT_LVL_HI;
		end
		return res;
	endfunction : f_clamp

	// Both factors are widened first, else the product wraps at the
	// width of the wider operand
	function automatic logic [LDT_DIV_W-1:0] f_lvl_num(
		input logic [LDT_LVL_W-1:0] c
	);
		logic [LDT_DIV_W-1:0] span;
		span = LDT_DIV_W'(c - LDT_LVL_LO);
		return span * LDT_DIV_W'(LDT_PCT_SPAN);
	endfunction : f_lvl_num

	function automatic logic [LDT_DIV_W-1:0] f_duty_num(
		input logic [LDT_CNT_W-1:0] high
	);
		logic [LDT_DIV_W-1:0] wide;
		wide = LDT_DIV_W'(high);
		return wide * LDT_DIV_W'(LDT_PCT_FULL);
	endfunction : f_duty_num

	function automatic logic [LDT_DIV_W-1:0] f_den_shift(
		input logic [LDT_DIV_W-1:0] den,
		input logic [2:0] idx
	);
		return den << idx;
	endfunction : f_den_shift

	// Pulse mode dims by the high duty, level mode lifts from the floor
	function automatic logic [LDT_PCT_W-1:0] f_pct(
		input logic pulse,
		input logic [LDT_QBITS-1:0] q
	);
		logic [LDT_PCT_W-1:0] res;
		if (pulse) begin
			res = LDT_PCT_FULL - q; // RULE_09
		end else begin
			res = LDT_PCT_FLOOR + q; // RULE_10
		end
		return res;
	endfunction : f_pct

	always_comb begin
		st_nxt = st_r;
		lvl_clamped = analog_dim_level;
		den_shift = '0;

		// Three-stage synchronisers; a change counts once stages 2 and 3 agree
		st_nxt.gate_s = f_shift(st_r.gate_s, gate_pwm_in);
		st_nxt.en_s = f_shift(st_r.en_s, chip_en_in);
		st_nxt.dim_s = f_shift(st_r.dim_s, analog_dim_input);
		st_nxt.gate_f = f_filter(st_r.gate_s, st_r.gate_f);
		st_nxt.en_f = f_filter(st_r.en_s, st_r.en_f);
		st_nxt.dim_f = f_filter(st_r.dim_s, st_r.dim_f);

		gate_on = f_open(st_r.gate_f, st_r.en_f); // RULE_17
		dim_rise = st_nxt.dim_f & ~st_r.dim_f;
		dim_fall = ~st_nxt.dim_f & st_r.dim_f;

		// Gate sequencer; the counter is exact at any high time, so short
		// pulses keep their width and a steady high just stays in ON
		st_nxt.gcnt = st_r.gcnt + 1'b1;
		unique case (st_r.gst)
			LDT_OFF: begin
				st_nxt.gcnt = '0;
				if (gate_on) begin
					st_nxt.gst = LDT_PRE; // RULE_01
				end
			end
			LDT_PRE: begin
				if (!gate_on) begin
					// Short pulse: remember its width, still wait out the delay
					st_nxt.glim = st_r.gcnt; // RULE_03 RULE_16
					st_nxt.gst = LDT_LATE;
				end else if (st_r.gcnt >= cfg.preboost_delay) begin
					st_nxt.gst = LDT_ON; // RULE_01 RULE_18
				end
			end
			LDT_LATE: begin
				if (st_r.gcnt >= cfg.preboost_delay) begin
					st_nxt.gcnt = '0;
					st_nxt.gst = LDT_POST; // RULE_03
				end
			end
			LDT_ON: begin
				st_nxt.gcnt = '0;
				st_nxt.glim = cfg.preboost_delay;
				if (!gate_on) begin
					st_nxt.gst = LDT_POST; // RULE_02 RULE_18
				end
			end
			LDT_POST: begin
				// Back to OFF; a new rise is taken from there on level
				if (st_r.gcnt >= st_r.glim) begin
					st_nxt.gst = LDT_OFF; // RULE_02
				end
			end
		endcase

		st_nxt.drive.boost_en = f_boost(st_nxt.gst); // RULE_01 RULE_02
		st_nxt.drive.sink_en = f_sink_vec(cfg.sink_select,
			f_sinks(st_nxt.gst)); // RULE_05

		// Dim input phase measurement
		if (st_r.since_rise != LDT_CNT_MAX) begin
			st_nxt.since_rise = st_r.since_rise + 1'b1;
		end
		if (dim_fall) begin
			st_nxt.high_len = f_len(st_r.since_rise); // RULE_20
			st_nxt.fall_seen = st_r.rise_seen;
		end
		if (dim_rise) begin
			st_nxt.since_rise = '0;
			st_nxt.rise_seen = 1'b1;
			if (st_r.rise_seen && st_r.fall_seen) begin
				// Second rise with a fall between: a real clock is present
				st_nxt.period = f_len(st_r.since_rise); // RULE_20
				st_nxt.period_ok = 1'b1;
				st_nxt.pulse_mode = 1'b1; // RULE_06
			end
		end else if (f_lost(st_r.since_rise, TIMEOUT_CNT)) begin
			// Lost clock; measurement is restarted from scratch
			st_nxt.pulse_mode = 1'b0; // RULE_07
			st_nxt.rise_seen = 1'b0;
			st_nxt.fall_seen = 1'b0;
			st_nxt.period_ok = 1'b0;
		end

		// Shared shift-subtract divider, one quotient bit per cycle; a fresh
		// result every eight cycles keeps settling far inside one millisecond
		if (!st_r.div_busy) begin
			st_nxt.div_busy = 1'b1;
			st_nxt.div_bit = LDT_QTOP;
			st_nxt.div_q = '0;
			if (st_r.pulse_mode && st_r.period_ok) begin
				st_nxt.div_pulse = 1'b1;
				st_nxt.div_rem = f_duty_num(st_r.high_len);
				st_nxt.div_den = LDT_DIV_W'(st_r.period);
			end else begin
				lvl_clamped = f_clamp(analog_dim_level); // RULE_11
				st_nxt.div_pulse = 1'b0;
				st_nxt.div_rem = f_lvl_num(lvl_clamped); // RULE_10
				st_nxt.div_den = LDT_DIV_W'(LDT_LVL_HI - LDT_LVL_LO);
			end
		end else begin
			den_shift = f_den_shift(st_r.div_den, st_r.div_bit);
			if (st_r.div_rem >= den_shift) begin
				st_nxt.div_rem = st_r.div_rem - den_shift;
				st_nxt.div_q[st_r.div_bit] = 1'b1;
			end
			st_nxt.div_bit = st_r.div_bit - 1'b1;
			if (st_r.div_bit == '0) begin
				st_nxt.div_busy = 1'b0;
				// Drop a result whose mode changed while it was computed
				if (st_r.div_pulse == st_r.pulse_mode) begin
					st_nxt.pct = f_pct(st_r.div_pulse,
						st_nxt.div_q); // RULE_09 RULE_10 RULE_14
				end
			end
		end
	end

	// Reset clears the synchronisers too, so the first filtered levels
	// are low like the idle pins and no false edge follows release; the
	// level output starts at the floor until the first divider run ends
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0; // RULE_19
			st_r.pct <= LDT_PCT_FLOOR;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign drive = st_r.drive;
	assign pulse_coded_dim_mode = st_r.pulse_mode;
	assign current_pct = st_r.pct;

endmodule : ldt_dimming_ctrl

//--- tb/ldt_host_model.sv
// Host model driving the dimming gate, chip enable and dim clock
`timescale 1ns/1ps
module ldt_host_model (
	input wire logic sys_clk,
	input wire logic dim_run,
	input wire logic [7:0] dim_hi,
	output logic gate_pwm_in,
	output logic chip_en_in,
	output logic analog_dim_input
);
	localparam int PER = 100;
	int ph = 0;
	initial begin
		gate_pwm_in = 1'b0;
		chip_en_in = 1'b1;
		analog_dim_input = 1'b0;
	end
	// Stopped clock rests low, as the pin pull-down would hold it
	always @(posedge sys_clk) begin
		ph <= (ph == PER - 1 || !dim_run) ? 0 : ph + 1;
		analog_dim_input <= dim_run && ph < dim_hi;
	end
	task automatic pulse(input int hi, input bit en);
		chip_en_in <= en;
		gate_pwm_in <= 1'b1;
		repeat (hi) @(posedge sys_clk);
		gate_pwm_in <= 1'b0;
		repeat (100) @(posedge sys_clk);
		chip_en_in <= 1'b1;
	endtask : pulse
endmodule : ldt_host_model

//--- tb/ldt_checker.sv
// Port checker for the dimming timing control
`timescale 1ns/1ps
module ldt_checker #(
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic gate_pwm_in,
	input wire logic chip_en_in,
	input wire logic analog_dim_input,
	input wire ldt_pkg::ldt_cfg_t cfg,
	input wire ldt_pkg::ldt_drive_t drive,
	input wire logic pulse_coded_dim_mode,
	input wire logic [ldt_pkg::LDT_PCT_W-1:0] current_pct
);
	import ldt_pkg::*;
	int pre = 0;
	int idle = 0;
	int chg = 0;
	int lm = 0;
	always_ff @(posedge sys_clk) begin
		pre <= (drive.boost_en && drive.sink_en == '0) ? pre + 1 : 0;
		idle <= $rose(analog_dim_input) ? 0 : idle + 1;
		chg <= $changed(analog_dim_input) ? 0 : chg + 1;
		lm <= pulse_coded_dim_mode ? 0 : lm + 1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_RESET_STATE: assert property ($fell(reset) |-> drive == '0
		&& !pulse_coded_dim_mode && current_pct == LDT_PCT_FLOOR)
		else $error("state not cleared by reset");
	// A stale pulse-mode result may stand for up to two divider runs
	AST_LEVEL_RANGE: assert property (lm > 20 |-> current_pct >=
		LDT_PCT_FLOOR && current_pct <= LDT_PCT_FULL) else $error("bad level");
	AST_SINK_MASK: assert property ((drive.sink_en & ~cfg.sink_select)
		== '0) else $error("unselected sink on");
	AST_SINK_BOOST: assert property (|drive.sink_en |-> drive.boost_en)
		else $error("sink on without boost");
	AST_BOOST_CAUSE: assert property ($rose(drive.boost_en) |->
		gate_pwm_in && chip_en_in && drive.sink_en == '0)
		else $error("boost rose without gate");
	AST_PRE_DELAY: assert property ($rose(|drive.sink_en) |->
		pre == cfg.preboost_delay + 1) else $error("pre-boost delay wrong");
	AST_MODE_ENTRY: assert property ($rose(pulse_coded_dim_mode) |->
		chg <= 8) else $error("pulse mode without clock");
	AST_MODE_TIMEOUT: assert property (pulse_coded_dim_mode |->
		idle <= TIMEOUT_CYC + 10) else $error("pulse mode kept too long");
	cover property ($rose(pulse_coded_dim_mode));
	cover property ($fell(pulse_coded_dim_mode));
	cover property ($rose(|drive.sink_en));
endmodule : ldt_checker

//--- tb/ldt_dimming_ctrl_tb.sv
// Self-checking bench for the dimming timing control
`timescale 1ns/1ps
module ldt_dimming_ctrl_tb;
	import ldt_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic run = 1'b0;
	logic [7:0] hi = 8'h32;
	logic [LDT_LVL_W-1:0] lvl = 8'h00;
	logic [7:0] codes [5] = '{8'h00, 8'h0E, 8'h0F, 8'h8B, 8'hFF};
	ldt_cfg_t cfg = '0;
	ldt_drive_t drive;
	logic gate, cen, adin, mode;
	logic [LDT_PCT_W-1:0] pct;
	int bad_count = 0;
	int n_tests = 0;
	int pre, on, x;
	ldt_host_model host (.sys_clk(sys_clk), .dim_run(run), .dim_hi(hi),
		.gate_pwm_in(gate), .chip_en_in(cen), .analog_dim_input(adin));
	ldt_dimming_ctrl #(.TIMEOUT_CYC(200)) dut (.sys_clk(sys_clk),
		.reset(reset), .gate_pwm_in(gate), .chip_en_in(cen),
		.analog_dim_input(adin), .analog_dim_level(lvl), .cfg(cfg),
		.drive(drive), .pulse_coded_dim_mode(mode), .current_pct(pct));
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int got, input int lo, input int up);
		n_tests++;
		if (got < lo || got > up) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, lo);
		end
	endtask : chk_cnt
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic lvl_run(input logic [7:0] c);
		@(posedge sys_clk);
		lvl <= c;
		x = (c <= LDT_LVL_LO) ? 10 : (c >= LDT_LVL_HI) ? 100 :
			10 + 90 * (c - LDT_LVL_LO) / (LDT_LVL_HI - LDT_LVL_LO);
		repeat (30) @(posedge sys_clk);
		#1;
		chk_val(pct, 16'(x));
	endtask : lvl_run
	task automatic gate_run(input int d, input int h, input bit en);
		@(posedge sys_clk);
		cfg.preboost_delay <= 16'(d);
		cfg.sink_select <= 6'($urandom) | 6'h01;
		pre = 0;
		on = 0;
		@(posedge sys_clk);
		fork
			host.pulse(h, en);
			repeat (h + 100) begin
				@(posedge sys_clk);
				#1;
				if (drive.boost_en === 1'b1 && drive.sink_en === '0 && on == 0)
					pre++;
				if (drive.sink_en !== '0) begin
					on++;
					chk_val(drive.sink_en, cfg.sink_select);
				end
			end
		join
		if (en) begin
			chk_cnt(pre, d + 1, d + 1);
			chk_cnt(on, h - 2, h + 2);
		end else
			chk_cnt(pre + on, 0, 0);
	endtask : gate_run
	task automatic pulse_coded_dim_mode_run(input logic [7:0] h);
		@(posedge sys_clk);
		hi <= h;
		run <= 1'b1;
		repeat (600) @(posedge sys_clk);
		#1;
		chk_val(mode, 1);
		chk_val(pct, 16'(100 - h));
	endtask : pulse_coded_dim_mode_run
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		finish_test();
	end
	initial begin
		void'($urandom(58143));
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk_val({drive, mode, pct}, {8'h00, LDT_PCT_FLOOR});
		$display("reset test done");
		foreach (codes[i]) lvl_run(codes[i]);
		repeat (3) lvl_run(8'($urandom));
		$display("level test done");
		gate_run(3, 200, 1);
		gate_run(0, 30, 1);
		gate_run(40, 30, 1);
		gate_run($urandom % 21, 500, 1);
		gate_run(3, 200, 0);
		$display("gate test done");
		repeat (3) pulse_coded_dim_mode_run(8'(15 + $urandom % 71));
		@(posedge sys_clk);
		run <= 1'b0;
		repeat (260) @(posedge sys_clk);
		#1;
		chk_val(mode, 0);
		$display("pulse mode test done");
		finish_test();
	end
endmodule : ldt_dimming_ctrl_tb
bind ldt_dimming_ctrl ldt_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
	.sys_clk(sys_clk), .reset(reset), .gate_pwm_in(gate_pwm_in),
	.chip_en_in(chip_en_in), .analog_dim_input(analog_dim_input),
	.cfg(cfg), .drive(drive), .pulse_coded_dim_mode(pulse_coded_dim_mode),
	.current_pct(current_pct));
